// File: src/csfb_defs.svh
// Purpose: constants of the charger status and flag bank
// Assumes: byte-wide registers behind a serial target port
// Notes:   definitions only
`ifndef CSFB_DEFS_SVH
`define CSFB_DEFS_SVH

// ****************************************************
// register offsets, masks, reset values
// ****************************************************
`define CSFB_ADDR_STATUS   8'h02
`define CSFB_ADDR_FLAG_CHG 8'h03
`define CSFB_ADDR_FLAG_FLT 8'h04
`define CSFB_ADDR_FLAG_ADC 8'h05
`define CSFB_RST_FLAG      8'h00
`define CSFB_MASK_STATUS   8'h71
`define CSFB_MASK_FLAG_CHG 8'h7f
`define CSFB_MASK_FLAG_FLT 8'hbf
`define CSFB_MASK_FLAG_ADC 8'hf1
`define CSFB_UNMAPPED      8'h00
// serial target address, value arbitrary
`define CSFB_DEV_ADDR      7'h2a
`define CSFB_BITS_PER_BYTE 4'h8

// ****************************************************
// field positions
// ****************************************************
`define CSFB_B_CMP_ONE     6
`define CSFB_B_CMP_TWO     5
`define CSFB_B_CMP_THREE   4
`define CSFB_B_THERM_OPEN  0
`define CSFB_B_TAPER       6
`define CSFB_B_DONE        5
`define CSFB_B_ILIM        4
`define CSFB_B_PATH        3
`define CSFB_B_VOLT_MGMT   2
`define CSFB_B_THERMAL     1
`define CSFB_B_PGOOD       0
`define CSFB_B_OVERVOLT    7
`define CSFB_B_OVERCUR     5
`define CSFB_B_UNDERVOLT   4
`define CSFB_B_COLD        3
`define CSFB_B_COOL        2
`define CSFB_B_WARM        1
`define CSFB_B_HOT         0
`define CSFB_B_ADC_READY   7

// ****************************************************
// synchronised input vector layout
// ****************************************************
`define CSFB_NIN           21
`define CSFB_IN_TAPER      0
`define CSFB_IN_DONE       1
`define CSFB_IN_ILIM       2
`define CSFB_IN_PATH       3
`define CSFB_IN_VOLT_MGMT  4
`define CSFB_IN_THERMAL    5
`define CSFB_IN_PGOOD      6
`define CSFB_IN_OVERVOLT   7
`define CSFB_IN_OVERCUR    8
`define CSFB_IN_UNDERVOLT  9
`define CSFB_IN_COLD       10
`define CSFB_IN_COOL       11
`define CSFB_IN_WARM       12
`define CSFB_IN_HOT        13
`define CSFB_IN_ADC        14
`define CSFB_IN_CMP_ONE    15
`define CSFB_IN_CMP_TWO    16
`define CSFB_IN_CMP_THREE  17
`define CSFB_IN_TOPEN      18
`define CSFB_IN_SCL        19
`define CSFB_IN_SDA        20

`endif

// File: src/csfb_pkg.sv
// Purpose: types of the charger status and flag bank
// Assumes: csfb_defs.svh on the include path
// Notes:   state of each module is one packed struct
`include "csfb_defs.svh"

package csfb_pkg;

  // ****************************************************
  // serial target states
  // ****************************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK,
    ST_WR, ST_WACK, ST_RD, ST_MACK
  } csfb_state_t;

  typedef struct packed {
    csfb_state_t st;
    logic [3:0]  cnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic        rw;
    logic        more;
    logic        sda_oe;
    logic        sda_out;
    logic [7:0]  flag_chg;
    logic [7:0]  flag_flt;
    logic [7:0]  flag_adc;
    logic [2:0]  live_prev;
  } csfb_main_t;

  typedef struct packed {
    logic [`CSFB_NIN-1:0] s1;
    logic [`CSFB_NIN-1:0] s2;
    logic [`CSFB_NIN-1:0] s3;
  } csfb_sync_t;

endpackage : csfb_pkg

// File: src/csfb_evt_if.sv
// Purpose: synchronised levels and edges between the modules
// Assumes: one clock domain
// Notes:   src drives, dst reads
`timescale 1ns/100ps
`include "csfb_defs.svh"

interface csfb_evt_if;
  logic [`CSFB_NIN-1:0] level;
  logic [`CSFB_NIN-1:0] rise;
  logic [`CSFB_NIN-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : csfb_evt_if

// File: src/csfb_evt_sync.sv
// Purpose: two-flop synchronisers and edge detection
// Assumes: raw inputs asynchronous to clk
// Notes:   first stage read only by second stage
`timescale 1ns/100ps

module csfb_evt_sync import csfb_pkg::*; (
  input  logic                 clk,
  input  logic                 reset,
  input  logic [`CSFB_NIN-1:0] raw_in,
  csfb_evt_if.src              ev
);

  csfb_sync_t q;
  csfb_sync_t n;

  always_comb begin
    n    = q;
    n.s1 = raw_in;
    n.s2 = q.s1;
    n.s3 = q.s2;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ****************************************************
  // per-bit edges, taken behind the second stage
  // ****************************************************
  for (genvar i = 0; i < `CSFB_NIN; i++) begin : g_edge
    assign ev.level[i] = q.s2[i];
    assign ev.rise[i]  = q.s2[i] & ~q.s3[i];
    assign ev.fall[i]  = ~q.s2[i] & q.s3[i];
  end

endmodule : csfb_evt_sync

// File: src/csfb_top.sv
// Purpose: status and latched event-flag bank of a charger
// Assumes: host reaches registers over the two-wire serial port
// Notes:   flags clear when their byte is loaded for a read
`timescale 1ns/100ps

module csfb_top import csfb_pkg::*; (
  input  logic clk,
  input  logic reset,
  input  logic scl,
  input  logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input  logic taper_active,
  input  logic charge_done,
  input  logic input_limit_active,
  input  logic path_mgmt_active,
  input  logic input_volt_mgmt_active,
  input  logic thermal_reg_active,
  input  logic input_good,
  input  logic input_overvolt,
  input  logic batt_overcurrent,
  input  logic batt_undervolt,
  input  logic therm_cold,
  input  logic therm_cool,
  input  logic therm_warm,
  input  logic therm_hot,
  input  logic adc_conv_done,
  input  logic cmp_one_above,
  input  logic cmp_two_above,
  input  logic cmp_three_above,
  input  logic therm_open,
  input  logic cmp_one_direction,
  input  logic cmp_two_direction,
  input  logic cmp_three_direction
);

  // ****************************************************
  // input gathering and synchronisers
  // ****************************************************
  logic [`CSFB_NIN-1:0] raw_in;
  csfb_evt_if           ev_if ();

  assign raw_in[`CSFB_IN_TAPER]     = taper_active;
  assign raw_in[`CSFB_IN_DONE]      = charge_done;
  assign raw_in[`CSFB_IN_ILIM]      = input_limit_active;
  assign raw_in[`CSFB_IN_PATH]      = path_mgmt_active;
  assign raw_in[`CSFB_IN_VOLT_MGMT] = input_volt_mgmt_active;
  assign raw_in[`CSFB_IN_THERMAL]   = thermal_reg_active;
  assign raw_in[`CSFB_IN_PGOOD]     = input_good;
  assign raw_in[`CSFB_IN_OVERVOLT]  = input_overvolt;
  assign raw_in[`CSFB_IN_OVERCUR]   = batt_overcurrent;
  assign raw_in[`CSFB_IN_UNDERVOLT] = batt_undervolt;
  assign raw_in[`CSFB_IN_COLD]      = therm_cold;
  assign raw_in[`CSFB_IN_COOL]      = therm_cool;
  assign raw_in[`CSFB_IN_WARM]      = therm_warm;
  assign raw_in[`CSFB_IN_HOT]       = therm_hot;
  assign raw_in[`CSFB_IN_ADC]       = adc_conv_done;
  assign raw_in[`CSFB_IN_CMP_ONE]   = cmp_one_above;
  assign raw_in[`CSFB_IN_CMP_TWO]   = cmp_two_above;
  assign raw_in[`CSFB_IN_CMP_THREE] = cmp_three_above;
  assign raw_in[`CSFB_IN_TOPEN]     = therm_open;
  assign raw_in[`CSFB_IN_SCL]       = scl;
  assign raw_in[`CSFB_IN_SDA]       = sda_in;

  csfb_evt_sync u_sync (
    .clk    (clk),
    .reset  (reset),
    .raw_in (raw_in),
    .ev     (ev_if.src)
  );

  // ****************************************************
  // bus conditions
  // ****************************************************
  logic scl_high;
  logic sda_level;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_high  = ev_if.level[`CSFB_IN_SCL];
  assign sda_level = ev_if.level[`CSFB_IN_SDA];
  assign scl_rise  = ev_if.rise[`CSFB_IN_SCL];
  assign scl_fall  = ev_if.fall[`CSFB_IN_SCL];
  // both lines pass equal delay, so edge order is kept
  assign bus_start = scl_high & ev_if.fall[`CSFB_IN_SDA];
  assign bus_stop  = scl_high & ev_if.rise[`CSFB_IN_SDA];

  // ****************************************************
  // live comparator and thermistor status
  // ****************************************************
  logic [2:0] live;
  logic [7:0] status;

  always_comb begin
    live[0] = cmp_one_direction ? ev_if.level[`CSFB_IN_CMP_ONE]
                                : ~ev_if.level[`CSFB_IN_CMP_ONE];
    live[1] = cmp_two_direction ? ev_if.level[`CSFB_IN_CMP_TWO]
                                : ~ev_if.level[`CSFB_IN_CMP_TWO];
    live[2] = cmp_three_direction ? ev_if.level[`CSFB_IN_CMP_THREE]
                                  : ~ev_if.level[`CSFB_IN_CMP_THREE];
    status = 8'h00;
    status[`CSFB_B_CMP_ONE]    = live[0];
    status[`CSFB_B_CMP_TWO]    = live[1];
    status[`CSFB_B_CMP_THREE]  = live[2];
    status[`CSFB_B_THERM_OPEN] = ev_if.level[`CSFB_IN_TOPEN];
    status = status & `CSFB_MASK_STATUS;
  end

  // ****************************************************
  // event sources per flag bit
  // ****************************************************
  logic [7:0] set_chg;
  logic [7:0] set_flt;
  logic [7:0] set_adc;

  always_comb begin
    set_chg = 8'h00;
    set_flt = 8'h00;
    set_adc = 8'h00;
    set_chg[`CSFB_B_TAPER]     = ev_if.rise[`CSFB_IN_TAPER];
    set_chg[`CSFB_B_DONE]      = ev_if.rise[`CSFB_IN_DONE];
    set_chg[`CSFB_B_ILIM]      = ev_if.rise[`CSFB_IN_ILIM];
    set_chg[`CSFB_B_PATH]      = ev_if.rise[`CSFB_IN_PATH];
    set_chg[`CSFB_B_VOLT_MGMT] = ev_if.rise[`CSFB_IN_VOLT_MGMT];
    set_chg[`CSFB_B_THERMAL]   = ev_if.rise[`CSFB_IN_THERMAL];
    set_chg[`CSFB_B_PGOOD]     = ev_if.rise[`CSFB_IN_PGOOD]
                               | ev_if.fall[`CSFB_IN_PGOOD];
    set_flt[`CSFB_B_OVERVOLT]  = ev_if.rise[`CSFB_IN_OVERVOLT];
    set_flt[`CSFB_B_OVERCUR]   = ev_if.rise[`CSFB_IN_OVERCUR];
    // inverted sense kept: set when battery leaves undervoltage
    set_flt[`CSFB_B_UNDERVOLT] = ev_if.fall[`CSFB_IN_UNDERVOLT];
    set_flt[`CSFB_B_COLD]      = ev_if.rise[`CSFB_IN_COLD];
    set_flt[`CSFB_B_COOL]      = ev_if.rise[`CSFB_IN_COOL];
    set_flt[`CSFB_B_WARM]      = ev_if.rise[`CSFB_IN_WARM];
    set_flt[`CSFB_B_HOT]       = ev_if.rise[`CSFB_IN_HOT];
    set_adc[`CSFB_B_ADC_READY] = ev_if.rise[`CSFB_IN_ADC];
    // a direction change that makes the condition true also counts
    set_adc[`CSFB_B_CMP_ONE]   = live[0] & ~q.live_prev[0];
    set_adc[`CSFB_B_CMP_TWO]   = live[1] & ~q.live_prev[1];
    set_adc[`CSFB_B_CMP_THREE] = live[2] & ~q.live_prev[2];
    set_adc[`CSFB_B_THERM_OPEN] = ev_if.rise[`CSFB_IN_TOPEN];
  end

  // ****************************************************
  // register read multiplexer
  // ****************************************************
  csfb_main_t q;
  csfb_main_t n;
  logic [7:0] rd_byte;

  always_comb begin
    unique case (q.ptr)
      `CSFB_ADDR_STATUS:   rd_byte = status;
      `CSFB_ADDR_FLAG_CHG: rd_byte = q.flag_chg;
      `CSFB_ADDR_FLAG_FLT: rd_byte = q.flag_flt;
      `CSFB_ADDR_FLAG_ADC: rd_byte = q.flag_adc;
      default:             rd_byte = `CSFB_UNMAPPED;
    endcase
  end

  // ****************************************************
  // serial target and flag update
  // ****************************************************
  always_comb begin
    logic load;
    logic [7:0] keep_chg;
    logic [7:0] keep_flt;
    logic [7:0] keep_adc;
    load     = 1'b0;
    n        = q;
    n.sda_out = 1'b0;
    n.live_prev = live;
    if (bus_stop) begin
      n.st     = ST_IDLE;
      n.sda_oe = 1'b0;
    end else if (bus_start) begin
      // repeated start lands here too and keeps the pointer
      n.st     = ST_ADDR;
      n.cnt    = 4'h0;
      n.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE: begin
          n.sda_oe = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            n.shreg = {q.shreg[6:0], sda_level};
            n.cnt   = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == `CSFB_BITS_PER_BYTE) begin
            if (q.shreg[7:1] == `CSFB_DEV_ADDR) begin
              n.rw     = q.shreg[0];
              n.sda_oe = 1'b1;
              n.st     = ST_AACK;
            end else begin
              n.st = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            n.cnt = 4'h0;
            if (q.rw) begin
              load = 1'b1;
              n.st = ST_RD;
            end else begin
              n.sda_oe = 1'b0;
              n.st     = ST_PTR;
            end
          end
        end
        ST_PTR: begin
          if (scl_rise) begin
            n.shreg = {q.shreg[6:0], sda_level};
            n.cnt   = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == `CSFB_BITS_PER_BYTE) begin
            n.ptr    = q.shreg;
            n.sda_oe = 1'b1;
            n.st     = ST_PACK;
          end
        end
        ST_PACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.cnt    = 4'h0;
            n.st     = ST_WR;
          end
        end
        ST_WR: begin
          // bytes are acknowledged but nothing here is writable
          if (scl_rise) begin
            n.shreg = {q.shreg[6:0], sda_level};
            n.cnt   = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == `CSFB_BITS_PER_BYTE) begin
            n.ptr    = q.ptr + 8'h01;
            n.sda_oe = 1'b1;
            n.st     = ST_WACK;
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.cnt    = 4'h0;
            n.st     = ST_WR;
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            n.cnt = q.cnt + 4'h1;
          end else if (scl_fall) begin
            if (q.cnt == `CSFB_BITS_PER_BYTE) begin
              n.sda_oe = 1'b0;
              n.st     = ST_MACK;
            end else begin
              n.shreg  = {q.shreg[6:0], 1'b0};
              n.sda_oe = ~q.shreg[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            n.more = ~sda_level;
          end else if (scl_fall) begin
            if (q.more) begin
              load  = 1'b1;
              n.cnt = 4'h0;
              n.st  = ST_RD;
            end else begin
              n.st = ST_IDLE;
            end
          end
        end
      endcase
    end

    // open drain: drive low for a zero bit, release for a one
    if (load) begin
      n.shreg  = rd_byte;
      n.ptr    = q.ptr + 8'h01;
      n.sda_oe = ~rd_byte[7];
    end

    // clear on load for read; a same-cycle event still lands
    keep_chg = (load && q.ptr == `CSFB_ADDR_FLAG_CHG) ?
               `CSFB_RST_FLAG : q.flag_chg;
    keep_flt = (load && q.ptr == `CSFB_ADDR_FLAG_FLT) ?
               `CSFB_RST_FLAG : q.flag_flt;
    keep_adc = (load && q.ptr == `CSFB_ADDR_FLAG_ADC) ?
               `CSFB_RST_FLAG : q.flag_adc;
    n.flag_chg = (keep_chg | set_chg) & `CSFB_MASK_FLAG_CHG;
    n.flag_flt = (keep_flt | set_flt) & `CSFB_MASK_FLAG_FLT;
    n.flag_adc = (keep_adc | set_adc) & `CSFB_MASK_FLAG_ADC;
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign sda_out = q.sda_out;
  assign sda_oe  = q.sda_oe;

endmodule : csfb_top

// File: testbench/csfb_props.sv
// Purpose: pin-level checks of the status and flag bank
// Assumes: sda_in is the resolved wire, pulled up when free
// Notes:   bus decoded from pins; bind after endmodule
`timescale 1ns/100ps
`include "csfb_defs.svh"

module csfb_props import csfb_pkg::*; (
  input logic clk,
  input logic reset,
  input logic scl,
  input logic sda_in,
  input logic sda_out,
  input logic sda_oe
);
  // ****************************************
  // pin decode
  // ****************************************
  logic       scl_q, sda_q, rd_q;
  logic [3:0] bit_q, byte_q;
  logic [7:0] sh_q, ptr_q;
  wire        rise  = scl && !scl_q;
  wire        start = scl && scl_q && sda_q && !sda_in;

  function automatic logic [7:0] live_mask(input logic [7:0] p);
    case (p)
      8'h02:   return 8'h71;
      8'h03:   return 8'h7f;
      8'h04:   return 8'hbf;
      8'h05:   return 8'hf1;
      default: return 8'h00;
    endcase
  endfunction : live_mask

  // stop needs no decode: the next start resets the counts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      rd_q   <= 1'b0;
      bit_q  <= 4'h0;
      byte_q <= 4'h0;
      sh_q   <= 8'h00;
      ptr_q  <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
      if (start) begin
        bit_q  <= 4'h0;
        byte_q <= 4'h0;
      end else if (rise && bit_q == 4'h8) begin
        bit_q <= 4'h0;
        if (byte_q != 4'hf) byte_q <= byte_q + 4'h1;
        if (byte_q == 4'h0) rd_q <= sh_q[0];
        else if (byte_q == 4'h1 && !rd_q) ptr_q <= sh_q;
        else ptr_q <= ptr_q + 8'h01;
      end else if (rise) begin
        bit_q <= bit_q + 4'h1;
        sh_q  <= {sh_q[6:0], sda_in};
      end
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence ack_slot;
    rise && bit_q == 4'h8;
  endsequence
  sequence addr_slot;
    ack_slot ##0 byte_q == 4'h0;
  endsequence
  sequence data_slot;
    ack_slot ##0 byte_q != 4'h0;
  endsequence

  drive_low_a: assert property (sda_out == 1'b0)
    else $error("sda output value not low");
  oe_reset_a: assert property ($past(reset) |-> !sda_oe)
    else $error("sda driven right after reset");
  oe_steady_a: assert property (scl && scl_q |-> $stable(sda_oe))
    else $error("sda drive changed while scl high");
  oe_late_a: assert property ($changed(sda_oe) |->
    !scl && !$past(scl) && !$past(scl, 2))
    else $error("sda drive changed too soon after scl fall");
  addr_ack_a: assert property (addr_slot ##0
    sh_q[7:1] == `CSFB_DEV_ADDR |-> sda_oe)
    else $error("own address not acknowledged");
  addr_nack_a: assert property (addr_slot ##0
    sh_q[7:1] != `CSFB_DEV_ADDR |-> !sda_oe)
    else $error("foreign address acknowledged");
  wr_ack_a: assert property (data_slot ##0 !rd_q |-> sda_oe)
    else $error("written byte not acknowledged");
  rd_free_a: assert property (data_slot ##0 rd_q |-> !sda_oe)
    else $error("line held during host acknowledge");
  rsvd_zero_a: assert property (data_slot ##0 rd_q |->
    (sh_q & ~live_mask(ptr_q)) == 8'h00)
    else $error("reserved or unmapped bit read as one");
endmodule : csfb_props

bind csfb_top csfb_props i_csfb_props (.clk(clk), .reset(reset),
  .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// File: testbench/csfb_host.sv
// Purpose: host controller model on the two-wire port
// Assumes: open-drain sda with pull-up, host owns scl
// Notes:   acts on falling clk edges; bit time 16 clocks
`timescale 1ns/100ps
`include "csfb_defs.svh"

module csfb_host import csfb_pkg::*; (
  input  logic clk,
  output logic scl,
  output logic sda_rel,
  input  logic sda
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold

  // s high: start, s low: stop; 12 clocks either way
  task automatic cond(input logic s);
    sda_rel = s;
    hold(4);
    scl = 1'b1;
    hold(4);
    sda_rel = !s;
    hold(4);
    if (s) scl = 1'b0;
  endtask : cond

  // data set early in the low phase, read mid high phase
  task automatic xbit(input logic v, output logic s);
    hold(2);
    sda_rel = v;
    hold(6);
    scl = 1'b1;
    hold(4);
    s = sda;
    hold(4);
    scl = 1'b0;
  endtask : xbit

  task automatic xbyte(input logic [7:0] tx, input logic ai,
                       output logic [7:0] rx, output logic ao);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      xbit(tx[i], b);
      rx[i] = b;
    end
    xbit(ai, ao);
  endtask : xbyte

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d,
                        output logic ok);
    logic [7:0] r;
    logic       k0, k1, k2;
    cond(1'b1);
    xbyte({`CSFB_DEV_ADDR, 1'b0}, 1'b1, r, k0);
    xbyte(a, 1'b1, r, k1);
    xbyte(d, 1'b1, r, k2);
    cond(1'b0);
    ok = !(k0 | k1 | k2);
  endtask : wr_reg

  // address ack of the read frame ends 468 clocks after entry
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                        output logic ok);
    logic [7:0] r;
    logic       k0, k1, k2, k3;
    cond(1'b1);
    xbyte({`CSFB_DEV_ADDR, 1'b0}, 1'b1, r, k0);
    xbyte(a, 1'b1, r, k1);
    cond(1'b0);
    cond(1'b1);
    xbyte({`CSFB_DEV_ADDR, 1'b1}, 1'b1, r, k2);
    xbyte(8'hff, 1'b1, d, k3);
    cond(1'b0);
    ok = !(k0 | k1 | k2);
  endtask : rd_reg

  task automatic probe(input logic [6:0] dev, output logic ack);
    logic [7:0] r;
    logic       k;
    cond(1'b1);
    xbyte({dev, 1'b0}, 1'b1, r, k);
    cond(1'b0);
    ack = !k;
  endtask : probe
endmodule : csfb_host

// File: testbench/testbench.sv
// Purpose: self-checking bench of the status and flag bank
// Assumes: inputs change on falling clk edges
// Notes:   expected bytes built from the register layout
`timescale 1ns/100ps
`include "csfb_defs.svh"

module testbench import csfb_pkg::*; ;
  // ****************************************
  // harness
  // ****************************************
  logic        clk, reset;
  logic [18:0] ev;
  logic [2:0]  dir;
  wire         scl, host_sda, sda_out, sda_oe;
  wire         sda_line = host_sda & ~sda_oe;
  int          failures, checks;
  localparam logic [7:0] flag_adr [19] = '{8'h03, 8'h03, 8'h03, 8'h03,
    8'h03, 8'h03, 8'h03, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04,
    8'h04, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05};
  localparam logic [7:0] flag_bit [19] = '{8'h40, 8'h20, 8'h10, 8'h08,
    8'h04, 8'h02, 8'h01, 8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02,
    8'h01, 8'h80, 8'h40, 8'h20, 8'h10, 8'h01};

  csfb_top i_csfb_top (
    .clk(clk), .reset(reset), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .taper_active(ev[0]), .charge_done(ev[1]),
    .input_limit_active(ev[2]), .path_mgmt_active(ev[3]),
    .input_volt_mgmt_active(ev[4]), .thermal_reg_active(ev[5]),
    .input_good(ev[6]), .input_overvolt(ev[7]),
    .batt_overcurrent(ev[8]), .batt_undervolt(ev[9]),
    .therm_cold(ev[10]), .therm_cool(ev[11]), .therm_warm(ev[12]),
    .therm_hot(ev[13]), .adc_conv_done(ev[14]),
    .cmp_one_above(ev[15]), .cmp_two_above(ev[16]),
    .cmp_three_above(ev[17]), .therm_open(ev[18]),
    .cmp_one_direction(dir[0]), .cmp_two_direction(dir[1]),
    .cmp_three_direction(dir[2]));
  csfb_host i_csfb_host (.clk(clk), .scl(scl), .sda_rel(host_sda),
    .sda(sda_line));

  always #12.5 clk = ~clk;

  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: answer %b, wanted %b", $time, got, exp);
    end
  endtask : cmp1

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    i_csfb_host.rd_reg(a, d, ok);
    cmp1(ok, 1'b1);
    cmp8(d, e);
  endtask : rd_chk

  // ****************************************
  // scenarios
  // ****************************************
  task automatic sc_reset();
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h05, 8'h00);
  endtask : sc_reset

  // one pulse per source; the second read proves the clear
  task automatic sc_events();
    for (int i = 0; i < 19; i++) begin
      ev[i] = 1'b1;
      tick(8);
      ev[i] = 1'b0;
      tick(8);
      rd_chk(flag_adr[i], flag_bit[i]);
      rd_chk(flag_adr[i], 8'h00);
    end
  endtask : sc_events

  task automatic sc_edges();
    ev[6] = 1'b1;
    tick(8);
    rd_chk(8'h03, 8'h01);
    ev[6] = 1'b0;
    tick(8);
    rd_chk(8'h03, 8'h01);
    ev[9] = 1'b1;
    tick(8);
    rd_chk(8'h04, 8'h00);
    ev[9] = 1'b0;
    tick(8);
    rd_chk(8'h04, 8'h10);
  endtask : sc_edges

  task automatic sc_live();
    dir = 3'b010;
    tick(8);
    rd_chk(8'h02, 8'h50);
    rd_chk(8'h05, 8'h50);
    ev[18] = 1'b1;
    ev[16] = 1'b1;
    tick(8);
    rd_chk(8'h02, 8'h71);
    ev[15] = 1'b1;
    ev[17] = 1'b1;
    ev[18] = 1'b0;
    ev[16] = 1'b0;
    tick(8);
    rd_chk(8'h02, 8'h00);
    dir = 3'b111;
    tick(8);
    ev[15] = 1'b0;
    ev[17] = 1'b0;
    tick(8);
    rd_chk(8'h05, 8'h71);
  endtask : sc_live

  task automatic sc_access();
    logic ok;
    i_csfb_host.wr_reg(8'h03, 8'hff, ok);
    cmp1(ok, 1'b1);
    i_csfb_host.wr_reg(8'h02, 8'hff, ok);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h10, 8'h00);
    i_csfb_host.probe(`CSFB_DEV_ADDR + 7'h01, ok);
    cmp1(ok, 1'b0);
  endtask : sc_access

  // sweep an event across the load of the flag byte
  task automatic sc_race();
    logic [7:0] r1, r2;
    logic       ok;
    for (int d = 0; d < 16; d++) begin
      fork
        i_csfb_host.rd_reg(8'h03, r1, ok);
        begin
          tick(460 + d);
          ev[0] = 1'b1;
          tick(6);
          ev[0] = 1'b0;
        end
      join
      i_csfb_host.rd_reg(8'h03, r2, ok);
      cmp8(r1 | r2, 8'h40);
      cmp1(r1[6] ^ r2[6], 1'b1);
    end
  endtask : sc_race

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    ev = '0;
    dir = 3'b111;
    failures = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    tick(8);
    sc_reset();
    sc_events();
    sc_edges();
    sc_live();
    sc_access();
    sc_race();
    close_out();
  end

  // a hang is cut short well inside the cycle budget
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    $display("unexpected at %0t: run too long", $time);
    close_out();
  end
endmodule : testbench
